/* File: pkg/cpc_map.vh */
`ifndef CPC_MAP_VH
`define CPC_MAP_VH
// physical encoder resolution, fixed
`define CPC_RES        16'h1000
`define CPC_RES_BITS   12
`define CPC_HALF_M1    27'h00007FF
// virtual resolution limits and reset
`define CPC_VRES_MIN   15'h0002
`define CPC_VRES_MAX   15'h7EF4
`define CPC_VRES_RST   15'h1000
// compensation mode codes
`define CPC_MODE_BLK   3'h1
`define CPC_MODE_BIT   3'h2
`define CPC_MODE_BLKS  3'h3
`define CPC_MODE_BITS  3'h4
`define CPC_MODE_RST   3'h2
// group size for blockwise compensation
`define CPC_GROUP      8
// error numbers
`define CPC_ERR_NONE   4'h0
`define CPC_ERR_RAM    4'h1
`define CPC_ERR_PROG   4'h2
`define CPC_ERR_NVMSUM 4'h3
`define CPC_ERR_NVMPL  4'h4
`define CPC_ERR_CAMPL  4'h5
`define CPC_ERR_TIME   4'h6
// register byte offsets
`define CPC_OFF_CTRL   6'h00
`define CPC_OFF_VRES   6'h04
`define CPC_OFF_ZERO   6'h08
`define CPC_OFF_STAT   6'h0C
`define CPC_OFF_POS    6'h10
`define CPC_OFF_SPEED  6'h14
`define CPC_OFF_ISTAT  6'h18
`define CPC_OFF_IMASK  6'h1C
`define CPC_OFF_IIDX   6'h20
`define CPC_OFF_IDATA  6'h24
`define CPC_OFF_VER    6'h28
// ctrl fields
`define CPC_CTRL_REV   0
`define CPC_CTRL_MODE  3:1
`define CPC_CTRL_R232  4
// interrupt bits
`define CPC_IRQ_READY  0
`define CPC_IRQ_ERR    1
`define CPC_IRQ_MSG    2
// timing
`define CPC_CLK_MHZ    200
`define CPC_TICK_US    100
`define CPC_START_S    10
`define CPC_CAM_MAX    16'h03E8
`endif

/* File: rtl/cpc_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "cpc_map.vh"
module cpc_top #(
	parameter TICK_CYC  = `CPC_TICK_US * `CPC_CLK_MHZ, // cycles per processing cycle
	parameter START_CYC = `CPC_START_S * 200000000,    // start-up limit in cycles
	parameter BUILD_CYC = 16,                          // build cycles per cam
	parameter PROG_WORDS = 16'h0400,                   // program memory words
	parameter NVM_WORDS  = 16'h0100,                   // parameter store words
	parameter VERSION   = 8'h01,                       // arbitrary version value
	parameter CHANNELS  = 16                           // outputs
) (
	input  wire        mclk_i,          // 200 MHz clock
	input  wire        arst_n_i,        // async reset, low
	input  wire [5:0]  avs_address,     // byte address
	input  wire        avs_read,        // read request
	input  wire        avs_write,       // write request
	input  wire [31:0] avs_writedata,   // write data
	output reg  [31:0] avs_readdata,    // read data
	output wire        avs_waitrequest, // stall
	input  wire [11:0] enc_gray_i,      // encoder position, gray
	input  wire [3:0]  plug_station_i,  // configuration plug
	input  wire [3:0]  cam_count_i,     // unused high bits guard
	input  wire [15:0] cam_total_i,     // programmed cam count
	output reg  [15:0] mem_addr_o,      // check memory address
	output reg         mem_sel_o,       // 0 program, 1 parameter store
	output reg         mem_rd_o,        // check memory read
	input  wire [15:0] mem_data_i,      // data, one cycle later
	output reg  [14:0] pos_o,           // scaled position
	input  wire [4:0]  adv_idx_i,       // channel*2+off edge
	output reg  [14:0] adv_pos_o,       // advanced scaled position
	output reg         build_o,         // cam table build running
	output reg         ready_o,         // unit ready
	output reg  [7:0]  prog_sel_o,      // program resumed
	output reg         resume_o,        // resume pulse
	output reg  [3:0]  station_o,       // bus station number
	output reg         msg_valid_o,     // status message valid
	input  wire        msg_ready_i,     // serial link takes it
	output reg  [15:0] msg_data_o,      // version and error
	output reg  [3:0]  err_num_o,       // error number
	output reg         relay_o,         // run-control relay on
	output reg         err_led_o,       // run-error indicator
	output wire        irq_o            // level interrupt
);
	localparam S_RAMW  = 3'h0; // write memory patterns
	localparam S_RAMR  = 3'h1; // read back and compare
	localparam S_PROG  = 3'h2; // program checksum
	localparam S_NVM   = 3'h3; // parameter store checksum
	localparam S_PLAUS = 3'h4; // plausibility checks
	localparam S_BUILD = 3'h5; // cam table generation
	localparam S_READY = 3'h6; // running
	localparam S_FAIL  = 3'h7; // halted with error

	// pin synchronisers, two flops each
	reg [11:0] enc_s1_r;   // first stage
	reg [11:0] enc_s2_r;   // second stage
	reg [3:0]  plug_s1_r;  // first stage
	reg [3:0]  plug_s2_r;  // second stage
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enc_s1_r  <= 12'h000;
			enc_s2_r  <= 12'h000;
			plug_s1_r <= 4'h0;
			plug_s2_r <= 4'h0;
		end else begin
			enc_s1_r  <= enc_gray_i;
			enc_s2_r  <= enc_s1_r;
			plug_s1_r <= plug_station_i;
			plug_s2_r <= plug_s1_r;
		end
	end

	// gray to binary; gray keeps the multi-bit crossing to one changing bit
	wire [11:0] enc_bin;   // decoded position
	genvar gi;
	generate
		for (gi = 0; gi < `CPC_RES_BITS; gi = gi + 1) begin : g_gray
			assign enc_bin[gi] = ^enc_s2_r[11:gi];
		end
	endgenerate

	// software registers
	reg        rev_r;      // reversal
	reg [2:0]  mode_r;     // compensation mode
	reg        r232_r;     // point-to-point link selected
	reg [14:0] vres_r;     // virtual resolution
	reg [11:0] zero_r;     // zero offset
	reg [2:0]  istat_r;    // sticky events
	reg [2:0]  imask_r;    // interrupt mask
	reg [4:0]  iidx_r;     // idle table pointer
	reg [13:0] idle_mem [0:31]; // idle times, 0.1 ms units
	reg [14:0] adv_mem  [0:31]; // working memory: advanced positions

	// direction, then zero offset, both modulo 4096
	wire [11:0] pos_dir  = rev_r ? (12'h000 - enc_bin) : enc_bin;
	wire [11:0] pos_phys = pos_dir - zero_r;

	// scale with rounding: remainder must exceed one half to round up
	function [14:0] scale;
		input [11:0] p;
		input [14:0] v;
		reg   [26:0] prod;
		reg   [26:0] q;
		begin
			prod  = {15'h0000, p} * {12'h000, v};
			q     = (prod + `CPC_HALF_M1) >> `CPC_RES_BITS;
			scale = (q[14:0] >= v) ? 15'h0000 : q[14:0];
		end
	endfunction

	// processing-cycle divider: one-cycle enable
	reg [31:0] tick_cnt_r; // divider count
	wire       tick = (tick_cnt_r == TICK_CYC - 1);
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			tick_cnt_r <= 32'h00000000;
		else if (tick)
			tick_cnt_r <= 32'h00000000;
		else
			tick_cnt_r <= tick_cnt_r + 32'h00000001;
	end

	// speed: increments per processing cycle, wrap-safe signed delta
	reg [11:0]        prev_r;  // position at last tick
	reg signed [11:0] speed_r; // measured speed
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_r  <= 12'h000;
			speed_r <= 12'sh000;
		end else if (tick) begin
			prev_r  <= pos_phys;
			speed_r <= pos_phys - prev_r;
		end
	end

	// idle entry per channel/edge from mode
	reg  [14:0] vres_nvm_r; // stored resolution
	reg  [3:0]  mode_nvm_r; // stored mode
	reg  [4:0] seq_r;     // compensation sequencer index
	reg        seq_run_r; // sequencer busy
	reg  [4:0] idle_sel;  // chosen idle entry
	reg        sep;       // separate on/off times
	always @* begin
		sep = (mode_r == `CPC_MODE_BLKS) || (mode_r == `CPC_MODE_BITS);
		case (mode_r)
			`CPC_MODE_BLK, `CPC_MODE_BLKS:
				idle_sel = {seq_r[4] , 3'h0, seq_r[0] & sep};
			`CPC_MODE_BIT, `CPC_MODE_BITS:
				idle_sel = {seq_r[4:1], seq_r[0] & sep};
			default: // unknown code treated as bitwise
				idle_sel = {seq_r[4:1], 1'b0};
		endcase
	end
	// shift forward by speed*idle so the cam fires earlier
	wire signed [26:0] adv = speed_r * $signed({1'b0, idle_mem[idle_sel]});
	wire [11:0] adv_phys = pos_phys + adv[11:0];

	// startup sequencer
	reg [2:0]  state_r;   // startup state
	reg [15:0] cnt_r;     // word counter
	reg        pend_r;    // read data due
	reg [15:0] pidx_r;    // index of pending word
	reg [15:0] sum_r;     // running checksum
	reg        pass_r;    // ram pattern pass
	reg [31:0] start_r;   // start-up elapsed cycles
	reg [31:0] build_r;   // build cycles left
	reg [3:0]  err_r;     // error number
	reg        msg_pend_r;// message owed
	wire [14:0] pat = {cnt_r[4:0], ~cnt_r[4:0], cnt_r[4:0]} ^ {15{pass_r}};
	wire [15:0] nwords = mem_sel_o ? NVM_WORDS : PROG_WORDS;
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r    <= S_RAMW;
			cnt_r      <= 16'h0000;
			pend_r     <= 1'b0;
			pidx_r     <= 16'h0000;
			sum_r      <= 16'h0000;
			pass_r     <= 1'b0;
			start_r    <= 32'h00000000;
			build_r    <= 32'h00000000;
			err_r      <= `CPC_ERR_NONE;
			mem_addr_o <= 16'h0000;
			mem_sel_o  <= 1'b0;
			mem_rd_o   <= 1'b0;
			build_o    <= 1'b0;
			ready_o    <= 1'b0;
			resume_o   <= 1'b0;
			prog_sel_o <= 8'h00;
			seq_r      <= 5'h00;
			seq_run_r  <= 1'b0;
			pos_o      <= 15'h0000;
		end else begin
			resume_o <= 1'b0;
			mem_rd_o <= 1'b0;
			pend_r   <= mem_rd_o;
			pidx_r   <= mem_addr_o;
			if (state_r != S_READY && state_r != S_FAIL) begin
				start_r <= start_r + 32'h00000001;
				if (start_r == START_CYC - 1) begin
					err_r   <= `CPC_ERR_TIME;
					build_o <= 1'b0;
					state_r <= S_FAIL;
				end
			end
			case (state_r)
				S_RAMW: begin
					adv_mem[cnt_r[4:0]] <= pat;
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r[4:0] == 5'h1F) begin
						cnt_r   <= 16'h0000;
						state_r <= S_RAMR;
					end
				end
				S_RAMR: begin
					cnt_r <= cnt_r + 16'h0001;
					if (adv_mem[cnt_r[4:0]] != pat) begin
						err_r   <= `CPC_ERR_RAM;
						state_r <= S_FAIL;
					end else if (cnt_r[4:0] == 5'h1F) begin
						cnt_r   <= 16'h0000;
						pass_r  <= ~pass_r;
						state_r <= pass_r ? S_PROG : S_RAMW;
					end
				end
				S_PROG, S_NVM: begin
					if (cnt_r < nwords) begin
						mem_rd_o   <= 1'b1;
						mem_addr_o <= cnt_r;
						cnt_r      <= cnt_r + 16'h0001;
					end
					if (pend_r) begin
						sum_r <= sum_r + mem_data_i;
						if (mem_sel_o && pidx_r == 16'h0000)
							vres_nvm_r <= mem_data_i[14:0];
						if (mem_sel_o && pidx_r == 16'h0001)
							mode_nvm_r <= mem_data_i[3:0];
						if (mem_sel_o && pidx_r == 16'h0002)
							prog_sel_o <= mem_data_i[7:0];
					end
					if (cnt_r == nwords && !mem_rd_o && !pend_r) begin
						cnt_r <= 16'h0000;
						sum_r <= 16'h0000;
						if (sum_r != 16'h0000) begin
							err_r   <= mem_sel_o ? `CPC_ERR_NVMSUM : `CPC_ERR_PROG;
							state_r <= S_FAIL;
						end else if (!mem_sel_o) begin
							mem_sel_o <= 1'b1;
							state_r   <= S_NVM;
						end else
							state_r <= S_PLAUS;
					end
				end
				S_PLAUS: begin
					if (vres_nvm_r < `CPC_VRES_MIN || vres_nvm_r > `CPC_VRES_MAX ||
					    mode_nvm_r[2:0] < `CPC_MODE_BLK ||
					    mode_nvm_r[2:0] > `CPC_MODE_BITS) begin
						err_r   <= `CPC_ERR_NVMPL;
						state_r <= S_FAIL;
					end else if (cam_total_i > `CPC_CAM_MAX) begin
						err_r   <= `CPC_ERR_CAMPL;
						state_r <= S_FAIL;
					end else begin
						// build time grows with the number of cams
						build_r <= cam_total_i * BUILD_CYC;
						build_o <= 1'b1;
						state_r <= S_BUILD;
					end
				end
				S_BUILD: begin
					if (build_r == 32'h00000000) begin
						build_o  <= 1'b0;
						ready_o  <= 1'b1;
						resume_o <= 1'b1;
						state_r  <= S_READY;
					end else
						build_r <= build_r - 32'h00000001;
				end
				S_READY: begin
					pos_o <= scale(pos_phys, vres_r);
					if (tick)
						seq_run_r <= 1'b1;
					if (seq_run_r) begin
						adv_mem[seq_r] <= scale(adv_phys, vres_r);
						seq_r <= seq_r + 5'h01;
						if (seq_r == 5'h1F)
							seq_run_r <= 1'b0;
					end
				end
				S_FAIL: begin
					ready_o <= 1'b0;
					build_o <= 1'b0;
				end
				default: state_r <= S_FAIL;
			endcase
		end
	end

	// advanced position read port, registered
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			adv_pos_o <= 15'h0000;
		else
			adv_pos_o <= adv_mem[adv_idx_i];
	end

	// error reporting and run outputs
	wire st_done = (state_r == S_READY) || (state_r == S_FAIL);
	reg  done_q_r; // previous done
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_num_o  <= `CPC_ERR_NONE;
			relay_o    <= 1'b0;
			err_led_o  <= 1'b0;
			station_o  <= 4'h0;
			done_q_r   <= 1'b0;
			msg_valid_o <= 1'b0;
			msg_data_o <= 16'h0000;
		end else begin
			err_num_o <= err_r;
			relay_o   <= ready_o && (err_r == `CPC_ERR_NONE);
			err_led_o <= (err_r != `CPC_ERR_NONE);
			// plug only; menu cannot write it, link select blanks it
			station_o <= r232_r ? 4'h0 : plug_s2_r;
			done_q_r  <= st_done;
			if (st_done && !done_q_r) begin
				msg_valid_o <= 1'b1;
				msg_data_o  <= {VERSION, 4'h0, err_r};
			end else if (msg_ready_i)
				msg_valid_o <= 1'b0;
		end
	end

	// avalon slave: one wait state per access
	reg  ack_r; // answer cycle
	wire req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_r;
	wire wr = avs_write & ack_r;
	wire [2:0] ev = {msg_valid_o & msg_ready_i,
	                 st_done & ~done_q_r & (err_r != `CPC_ERR_NONE),
	                 st_done & ~done_q_r & (err_r == `CPC_ERR_NONE)};
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_r        <= 1'b0;
			avs_readdata <= 32'h00000000;
			rev_r        <= 1'b0;
			mode_r       <= `CPC_MODE_RST;
			r232_r       <= 1'b0;
			vres_r       <= `CPC_VRES_RST;
			zero_r       <= 12'h000;
			istat_r      <= 3'h0;
			imask_r      <= 3'h0;
			iidx_r       <= 5'h00;
		end else begin
			ack_r <= req & ~ack_r;
			// events win over a clearing write in the same cycle
			istat_r <= (istat_r & ~((wr && avs_address == `CPC_OFF_ISTAT) ?
			            avs_writedata[2:0] : 3'h0)) | ev;
			if (state_r == S_PLAUS) begin
				vres_r <= vres_nvm_r;
				mode_r <= mode_nvm_r[2:0];
				rev_r  <= mode_nvm_r[3];
			end
			if (req & ~ack_r) begin
				case (avs_address)
					`CPC_OFF_CTRL:  avs_readdata <= {27'h0, r232_r, mode_r, rev_r};
					`CPC_OFF_VRES:  avs_readdata <= {17'h0, vres_r};
					`CPC_OFF_ZERO:  avs_readdata <= {20'h0, zero_r};
					`CPC_OFF_STAT:  avs_readdata <= {12'h0, station_o, 4'h0,
					                 err_r, 6'h0, ready_o, build_o};
					`CPC_OFF_POS:   avs_readdata <= {17'h0, pos_o};
					`CPC_OFF_SPEED: avs_readdata <= {{20{speed_r[11]}}, speed_r};
					`CPC_OFF_ISTAT: avs_readdata <= {29'h0, istat_r};
					`CPC_OFF_IMASK: avs_readdata <= {29'h0, imask_r};
					`CPC_OFF_IIDX:  avs_readdata <= {27'h0, iidx_r};
					`CPC_OFF_IDATA: avs_readdata <= {18'h0, idle_mem[iidx_r]};
					`CPC_OFF_VER:   avs_readdata <= {24'h0, VERSION};
					default:        avs_readdata <= 32'h00000000;
				endcase
			end
			if (wr) begin
				case (avs_address)
					`CPC_OFF_CTRL: begin
						rev_r  <= avs_writedata[`CPC_CTRL_REV];
						mode_r <= avs_writedata[`CPC_CTRL_MODE];
						r232_r <= avs_writedata[`CPC_CTRL_R232];
					end
					`CPC_OFF_VRES: // out-of-range values are refused
						if (avs_writedata[14:0] >= `CPC_VRES_MIN &&
						    avs_writedata[14:0] <= `CPC_VRES_MAX &&
						    avs_writedata[31:15] == 17'h0)
							vres_r <= avs_writedata[14:0];
					`CPC_OFF_ZERO:  zero_r  <= avs_writedata[11:0];
					`CPC_OFF_IMASK: imask_r <= avs_writedata[2:0];
					`CPC_OFF_IIDX:  iidx_r  <= avs_writedata[4:0];
					default: ;
				endcase
			end
		end
	end

	// idle time table write port
	always @(posedge mclk_i) begin
		if (wr && avs_address == `CPC_OFF_IDATA)
			idle_mem[iidx_r] <= avs_writedata[13:0];
	end

	assign irq_o = |(istat_r & imask_r);
endmodule
`default_nettype wire

/* File: test/cam_position_conditioning_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpc_map.vh"
module cam_position_conditioning_bench;
	localparam [7:0] VER = 8'h5C; // arbitrary version value
	reg         mclk_i = 1'b0, arst_n_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	reg  [5:0]  avs_address = 6'h00;
	reg  [31:0] avs_writedata = 32'h0;
	reg  [3:0]  plug_station_i = 4'h9;
	reg  [15:0] cam_total_i = 16'h0004;
	reg  [4:0]  adv_idx_i = 5'h00;
	reg  [11:0] raw = 12'h000;
	reg         spin = 1'b0;
	reg  [1:0]  bad = 2'h0;
	reg  [15:0] lf = 16'h0026;
	wire [31:0] avs_readdata;
	wire [15:0] mem_addr_o, mem_data_i, msg_data_o;
	wire [14:0] pos_o, adv_pos_o;
	wire [11:0] enc_gray_i;
	wire [7:0]  prog_sel_o;
	wire [3:0]  station_o, err_num_o;
	wire        avs_waitrequest, mem_sel_o, mem_rd_o, build_o, ready_o, resume_o;
	wire        msg_valid_o, msg_ready_i, relay_o, err_led_o, irq_o;
	integer     errors = 0, total_checks = 0, cyc = 0;
	integer     k, j, t, t1, a, b, n, vr, zr;
	reg  [31:0] q;

	always #2.5 mclk_i = ~mclk_i;

	cpc_top #(.TICK_CYC(50), .START_CYC(100000), .PROG_WORDS(16'h0008),
		.NVM_WORDS(16'h0008), .VERSION(VER)) uut (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.enc_gray_i(enc_gray_i), .plug_station_i(plug_station_i), .cam_count_i(lf[3:0]),
		.cam_total_i(cam_total_i), .mem_addr_o(mem_addr_o), .mem_sel_o(mem_sel_o),
		.mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .pos_o(pos_o),
		.adv_idx_i(adv_idx_i), .adv_pos_o(adv_pos_o), .build_o(build_o),
		.ready_o(ready_o), .prog_sel_o(prog_sel_o), .resume_o(resume_o),
		.station_o(station_o), .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i),
		.msg_data_o(msg_data_o), .err_num_o(err_num_o), .relay_o(relay_o),
		.err_led_o(err_led_o), .irq_o(irq_o));

	cpc_encmem far (
		.mclk_i(mclk_i), .raw_i(raw), .spin_i(spin), .bad_i(bad),
		.mem_addr_i(mem_addr_o), .mem_sel_i(mem_sel_o), .mem_rd_i(mem_rd_o),
		.mem_data_o(mem_data_i), .enc_gray_o(enc_gray_i),
		.msg_valid_i(msg_valid_o), .msg_ready_o(msg_ready_i));

	// hang guard: whole run needs far fewer cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors = errors + 1;
			results;
		end
	end

	function [15:0] nxt(input [15:0] s);
		nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// rounding: remainder above half goes up, full turn wraps to 0
	function integer scl(input integer p, input integer v);
		integer r;
		begin
			r = (p * v + 2047) / 4096;
			scl = (r == v) ? 0 : r;
		end
	endfunction
	// idle entry used: group head when blockwise, on entry unless split
	function integer idl(input integer md, input integer x);
		integer c;
		begin
			c = (md == 1 || md == 3) ? (x >> 1) & 8 : x >> 1;
			idl = c * 2 + ((md >= 3) ? x % 2 : 0);
		end
	endfunction

	task chk(input [31:0] got, input [31:0] exp, input [8*10:1] nm);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("wrong value %0s expected %0h seen %0h", nm, exp, got);
			end
		end
	endtask
	// one bus access; held until waitrequest is sampled low at a rising edge
	task bus(input w, input [5:0] ad, input [31:0] d);
		begin
			@(posedge mclk_i);
			avs_address   <= ad;
			avs_writedata <= d;
			avs_write     <= w;
			avs_read      <= !w;
			@(posedge mclk_i);
			while (avs_waitrequest !== 1'b0)
				@(posedge mclk_i);
			q = avs_readdata;
			avs_write <= 1'b0;
			avs_read  <= 1'b0;
		end
	endtask
	task rg(input [5:0] ad, input [31:0] e, input [8*10:1] nm);
		begin
			bus(1'b0, ad, 32'h0);
			chk(q, e, nm);
		end
	endtask
	task look(input integer c);
		begin
			repeat (c) @(posedge mclk_i);
			@(negedge mclk_i);
		end
	endtask
	// reset, run start-up, check outcome and its message
	task boot(input [15:0] cams, input [1:0] bd, input [3:0] ee);
		begin
			@(posedge mclk_i);
			arst_n_i <= 1'b0;
			cam_total_i <= cams;
			bad <= bd;
			repeat (12) @(posedge mclk_i);
			arst_n_i <= 1'b1;
			t = 0;
			while (!ready_o && err_num_o === 4'h0 && t < 3000) begin
				@(negedge mclk_i);
				t = t + 1;
			end
			look(2);
			chk(err_num_o, ee, "err_num");
			chk({ready_o, relay_o, err_led_o}, (ee == 4'h0) ? 3'h6 : 3'h1, "flags");
			if (ee == 4'h0)
				chk(prog_sel_o, 8'h2A, "prog_sel");
			n = 0;
			while (msg_valid_o !== 1'b1 && n < 20) begin
				@(negedge mclk_i);
				n = n + 1;
			end
			chk(msg_data_o, {VER, 4'h0, ee}, "msg_data");
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	initial begin
		// faulty start-ups: too many cams, then each bad sum, then a bad stored resolution
		for (k = 0; k < 4; k = k + 1)
			boot((k == 0) ? 16'h03E9 : 16'h0004, k[1:0], (k == 0) ? 4'h5 : 4'h1 + k[3:0]);
		boot(16'h000A, 2'h0, 4'h0);
		t1 = t;
		boot(16'h0004, 2'h0, 4'h0);
		chk(t1 - t, 96, "start_len");
		chk(station_o, 4'h9, "station");
		rg(`CPC_OFF_CTRL, 32'h7, "ctrl");
		rg(`CPC_OFF_VRES, 32'h1000, "vres");
		bus(1'b1, `CPC_OFF_VRES, 32'h1);
		bus(1'b1, `CPC_OFF_VRES, 32'h7EF5);
		rg(`CPC_OFF_VRES, 32'h1000, "vres_keep");
		rg(6'h3C, 32'h0, "unmapped");
		bus(1'b1, `CPC_OFF_STAT, 32'h0);
		bus(1'b1, `CPC_OFF_CTRL, 32'h14);
		look(4);
		chk(station_o, 4'h0, "station");
		bus(1'b1, `CPC_OFF_CTRL, 32'h4);
		look(4);
		chk(station_o, 4'h9, "station");
		@(posedge mclk_i);
		plug_station_i <= 4'h3;
		look(4);
		chk(station_o, 4'h3, "station");
		// interrupt: masked, unmasked, cleared
		bus(1'b1, `CPC_OFF_IMASK, 32'h0);
		look(2);
		chk(irq_o, 1'b0, "irq");
		bus(1'b1, `CPC_OFF_IMASK, 32'h1);
		look(2);
		chk(irq_o, 1'b1, "irq");
		bus(1'b1, `CPC_OFF_ISTAT, 32'h1);
		look(2);
		chk(irq_o, 1'b0, "irq");
		// position: reversal, zero offset, scaling and rounding
		for (k = 0; k < 8; k = k + 1) begin
			lf = nxt(lf);
			vr = (k == 0) ? 4096 : (k == 1) ? 2 : (k == 2) ? 32500 : 2 + lf % 32499;
			lf = nxt(lf);
			zr = (k == 1) ? 0 : lf[11:0];
			lf = nxt(lf);
			bus(1'b1, `CPC_OFF_CTRL, {28'h0, 3'h2, k[0]});
			bus(1'b1, `CPC_OFF_VRES, vr);
			bus(1'b1, `CPC_OFF_ZERO, zr);
			raw <= (k == 1) ? 12'hC00 : lf[11:0];
			look(20);
			a = ((k % 2) ? 4096 - raw : raw) - zr + 8192;
			chk(pos_o, scl(a % 4096, vr), "pos_o");
		end
		// cam advance per mode with steady rotation of 3 per cycle
		bus(1'b1, `CPC_OFF_CTRL, 32'h4);
		bus(1'b1, `CPC_OFF_VRES, 32'h1000);
		bus(1'b1, `CPC_OFF_ZERO, 32'h0);
		for (j = 0; j < 32; j = j + 1) begin
			bus(1'b1, `CPC_OFF_IIDX, j);
			bus(1'b1, `CPC_OFF_IDATA, j);
		end
		rg(`CPC_OFF_IDATA, 32'h1F, "idle");
		spin <= 1'b1;
		look(200);
		rg(`CPC_OFF_SPEED, 32'h96, "speed");
		for (k = 1; k < 5; k = k + 1) begin
			bus(1'b1, `CPC_OFF_CTRL, {28'h0, k[2:0], 1'b0});
			for (j = 0; j < 5; j = j + 1) begin
				n = (j == 0) ? 1 : (j == 1) ? 7 : (j == 2) ? 18 : (j == 3) ? 23 : 30;
				look(60);
				b = adv_pos_o;
				t = 0;
				while (adv_pos_o === b[14:0] && t < 200) begin
					@(negedge mclk_i);
					t = t + 1;
				end
				repeat (30) @(posedge mclk_i);
				adv_idx_i <= n[4:0];
				look(2);
				a = adv_pos_o;
				@(posedge mclk_i);
				adv_idx_i <= 5'h00;
				look(2);
				b = adv_pos_o;
				chk((a - b) & 4095, (3 * n + 150 * idl(k, n)) & 4095, "advance");
			end
		end
		results;
	end
endmodule

bind cpc_top cpc_props u_props (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .mem_addr_o(mem_addr_o), .mem_sel_o(mem_sel_o),
	.mem_rd_o(mem_rd_o), .build_o(build_o), .ready_o(ready_o), .resume_o(resume_o),
	.msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i), .msg_data_o(msg_data_o),
	.err_num_o(err_num_o), .relay_o(relay_o), .err_led_o(err_led_o));
`default_nettype wire

/* File: test/cpc_encmem.sv */
`timescale 1ns/1ps
`default_nettype none
module cpc_encmem #(
	parameter STEP_CYC = 1 // cycles per shaft step of 3
) (
	input  wire        mclk_i,      // clock
	input  wire [11:0] raw_i,       // held position
	input  wire        spin_i,      // steady rotation
	input  wire [1:0]  bad_i,       // 1 prog sum, 2 store sum, 3 store vres
	input  wire [15:0] mem_addr_i,  // word address
	input  wire        mem_sel_i,   // 0 program, 1 store
	input  wire        mem_rd_i,    // word read
	output reg  [15:0] mem_data_o,  // word, one cycle later
	output reg  [11:0] enc_gray_o,  // gray position
	input  wire        msg_valid_i, // status message
	output reg         msg_ready_o  // message taken
);
	reg [11:0] pos_r  = 12'h000; // shaft position
	integer    cnt_r  = 0;       // step timer
	integer    slow_r = 0;       // wait for message
	reg        fast_r = 1'b0;    // prompt or slow answer
	initial mem_data_o  = 16'h0000;
	initial enc_gray_o  = 12'h000;
	initial msg_ready_o = 1'b0;

	// word contents; the last word balances each sum to zero
	function [15:0] word(input s, input [2:0] a);
		reg [15:0] w0;
		begin
			w0 = (bad_i == 2'h3) ? 16'h0001 : 16'h1000;
			if (!s)
				word = (a == 3'h7) ? 16'h0000 - 16'h1111 * 21 : 16'h1111 * a;
			else
				case (a)
					3'h0: word = w0;
					3'h1: word = 16'h000B;
					3'h2: word = 16'h002A;
					3'h7: word = 16'h0000 - w0 - 16'h0035;
					default: word = 16'h0000;
				endcase
			if ((bad_i == 2'h1 && !s && a == 3'h1) || (bad_i == 2'h2 && s && a == 3'h3))
				word = word ^ 16'h0001;
		end
	endfunction

	// memory answers, shaft and message handshake
	always @(posedge mclk_i) begin
		// an idle data line inverts the last word each cycle
		mem_data_o <= mem_rd_i ? word(mem_sel_i, mem_addr_i[2:0]) : ~mem_data_o;
		cnt_r <= (cnt_r == STEP_CYC - 1) ? 0 : cnt_r + 1;
		if (!spin_i)
			pos_r <= raw_i;
		else if (cnt_r == 0)
			pos_r <= pos_r + 12'h003;
		enc_gray_o  <= pos_r ^ (pos_r >> 1);
		msg_ready_o <= msg_valid_i && !msg_ready_o && slow_r >= (fast_r ? 0 : 3);
		slow_r <= msg_valid_i ? slow_r + 1 : 0;
		if (msg_ready_o)
			fast_r <= !fast_r;
	end
endmodule
`default_nettype wire

/* File: test/cpc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cpc_props (
	input wire        mclk_i,          // clock
	input wire        arst_n_i,        // reset, low
	input wire        avs_read,        // bus read
	input wire        avs_write,       // bus write
	input wire        avs_waitrequest, // bus stall
	input wire [15:0] mem_addr_o,      // check address
	input wire        mem_sel_o,       // memory select
	input wire        mem_rd_o,        // check read
	input wire        build_o,         // table build
	input wire        ready_o,         // ready
	input wire        resume_o,        // resume pulse
	input wire        msg_valid_o,     // message valid
	input wire        msg_ready_i,     // message taken
	input wire [15:0] msg_data_o,      // message word
	input wire [3:0]  err_num_o,       // error number
	input wire        relay_o,         // run relay
	input wire        err_led_o        // error lamp
);
	// one clock domain, so one default for all
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	// one wait state, then the answer
	wait_one_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	test_first_a: assert property (
		mem_rd_o |-> !build_o && !ready_o) else $error("check read after start-up");
	mem_order_a: assert property (
		mem_rd_o && $past(mem_rd_o) && mem_sel_o == $past(mem_sel_o)
		|-> mem_addr_o == $past(mem_addr_o) + 16'h0001) else $error("check address skipped");
	build_ready_a: assert property (
		build_o |-> !ready_o) else $error("ready during build");
	resume_pulse_a: assert property (
		$rose(ready_o) |-> resume_o ##1 !resume_o) else $error("resume pulse wrong");
	ready_hold_a: assert property (
		ready_o |=> ready_o) else $error("ready dropped");
	relay_state_a: assert property (
		relay_o |-> ready_o && err_num_o == 4'h0 && !err_led_o) else $error("relay on wrongly");
	err_show_a: assert property (
		err_num_o != 4'h0 |-> ##[0:1] (err_led_o && !relay_o)) else $error("error not shown");
	msg_hold_a: assert property (
		msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_data_o))
		else $error("message not held");
	msg_drop_a: assert property (
		msg_valid_o && msg_ready_i |=> !msg_valid_o) else $error("message not dropped");
	msg_raise_a: assert property (
		$rose(ready_o) |-> ##[0:2] msg_valid_o) else $error("no start-up message");
endmodule
`default_nettype wire
